// ===== adcc_top.sv
// Converter multiplexer, reference and conversion control.
// ------------------------------------------------------------------
// ------------------------------------------------------------------
//
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/1ns
`include "adcc_consts.svh"
module adcc_top import adcc_pkg::*; (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rdata,
    input wire logic global_irq_enable,
    input wire logic irq_vector_ack,
    input wire logic [7:0] trigger_flags,
    input wire logic [9:0] core_result,
    output logic converter_power,
    output logic conv_active,
    output logic [1:0] ref_source,
    output logic [2:0] input_kind,
    output logic [3:0] se_channel,
    output logic [2:0] diff_pair,
    output logic gain_20x,
    output logic irq_request
);

    // ------------------------------------------------------------------
    // State and links
    // ------------------------------------------------------------------
    adcc_top_s s_r;
    adcc_top_s s_nxt;
    adcc_if link ();
    logic done;
    logic starting;
    logic trig_level;
    logic trig_edge;
    logic [4:0] last_cnt;

    adcc_prescaler u_presc (
        .mclk(mclk),
        .rst(rst),
        .bus(link)
    );

    adcc_result u_result (
        .mclk(mclk),
        .rst(rst),
        .bus(link)
    );

    // ------------------------------------------------------------------
    // Decoding functions
    // ------------------------------------------------------------------
    function automatic adcc_ref_e ref_decode(input logic [1:0] sel,
                                             input logic ext);
        adcc_ref_e r;
        if (!sel[0]) begin
            r = ext ? ADCC_REF_EXT : ADCC_REF_AVCC;
        end else begin
            r = sel[1] ? ADCC_REF_2V56 : ADCC_REF_1V1;
        end
        return r;
    endfunction : ref_decode

    function automatic adcc_input_e in_decode(input logic [4:0] code);
        adcc_input_e k;
        if (code[4]) begin
            k = ADCC_IN_DIFF;
        end else if (code[3:0] <= 4'hA) begin
            k = ADCC_IN_EXT;
        end else if (code[3:0] == 4'hB) begin
            k = ADCC_IN_TEMP;
        end else if (code[3:0] == 4'hC) begin
            k = ADCC_IN_BANDGAP;
        end else if (code[3:0] == 4'hD) begin
            k = ADCC_IN_VCC4;
        end else if (code[3:0] == 4'hE) begin
            k = ADCC_IN_GND;
        end else begin
            k = ADCC_IN_RSVD;
        end
        return k;
    endfunction : in_decode

    function automatic logic is_reg(input logic [2:0] a,
                                    input logic [2:0] off);
        return a == off;
    endfunction : is_reg

    // ------------------------------------------------------------------
    // Links to prescaler and result holder
    // ------------------------------------------------------------------
    assign link.enable = s_r.en;
    assign link.restart = starting;
    assign link.div_sel = s_r.ps;
    assign link.load = done;
    assign link.data = core_result;
    assign link.left_adjust = s_r.mux[`ADCC_MUX_LADJ];
    assign link.rd_low = rd_en && is_reg(addr, `ADCC_OFF_RES_LO);
    assign link.rd_high = rd_en && is_reg(addr, `ADCC_OFF_RES_HI);

    // Free running uses the own completion flag as its trigger source.
    assign trig_level = (s_r.trig_sel == 3'h0) ? s_r.flag
                                               : trigger_flags[s_r.trig_sel];
    assign trig_edge = s_r.ate && trig_level && !s_r.trig_prev;
    assign last_cnt = s_r.long_cur ? (`ADCC_CONV_LONG - 5'h01)
                                   : (`ADCC_CONV_NORMAL - 5'h01);
    assign done = (s_r.state == ADCC_CONV) && s_r.en && link.tick
                  && (s_r.cnt == last_cnt);

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        starting = 1'b0;
        s_nxt.rdata = 8'h00;
        s_nxt.trig_prev = trig_level;

        if (wr_en && is_reg(addr, `ADCC_OFF_MUX)) begin
            if (wdata[7:6] != s_r.mux[7:6]) begin
                s_nxt.long_next = 1'b1;
            end
            s_nxt.mux = wdata;
        end else if (wr_en && is_reg(addr, `ADCC_OFF_CSRA)) begin
            s_nxt.en = wdata[`ADCC_CSRA_EN];
            s_nxt.ate = wdata[`ADCC_CSRA_ATE];
            s_nxt.ie = wdata[`ADCC_CSRA_IE];
            s_nxt.ps = wdata[2:0];
            if (wdata[`ADCC_CSRA_FLAG]) begin
                s_nxt.flag = 1'b0;
            end
            if (wdata[`ADCC_CSRA_EN] && !s_r.en) begin
                s_nxt.long_next = 1'b1;
            end
        end else if (wr_en && is_reg(addr, `ADCC_OFF_CTRLB)) begin
            s_nxt.trig_sel = wdata[2:0];
            if (wdata[2:0] == 3'h0) begin
                s_nxt.trig_prev = 1'b1;
            end
        end else if (wr_en && is_reg(addr, `ADCC_OFF_AMISC)) begin
            s_nxt.ext_ref = wdata[`ADCC_AMISC_EXTREF];
        end

        if (irq_vector_ack) begin
            s_nxt.flag = 1'b0;
        end

        case (s_r.state)
            ADCC_IDLE: begin
                // A start written with zero does nothing.
                if (s_nxt.en && (trig_edge || (wr_en
                    && is_reg(addr, `ADCC_OFF_CSRA)
                    && wdata[`ADCC_CSRA_START]))) begin
                    starting = 1'b1;
                    s_nxt.state = ADCC_CONV;
                    s_nxt.cnt = 5'h00;
                    s_nxt.long_cur = s_nxt.long_next;
                    s_nxt.long_next = 1'b0;
                    s_nxt.ref_out = ref_decode(s_nxt.mux[7:6],
                                               s_nxt.ext_ref);
                    s_nxt.kind = in_decode(s_nxt.mux[4:0]);
                    s_nxt.se = s_nxt.mux[3:0];
                    s_nxt.pair = s_nxt.mux[3:1];
                    s_nxt.g20 = s_nxt.mux[0];
                end
            end
            ADCC_CONV: begin
                if (!s_nxt.en) begin
                    s_nxt.state = ADCC_IDLE;
                end else if (done) begin
                    s_nxt.state = ADCC_IDLE;
                    s_nxt.flag = 1'b1;
                end else if (link.tick) begin
                    s_nxt.cnt = s_r.cnt + 5'h01;
                end
            end
            default: begin
                s_nxt.state = ADCC_IDLE;
            end
        endcase

        // Setting wins over any clear in the same cycle.
        s_nxt.irq = s_nxt.flag && s_nxt.ie && global_irq_enable;

        if (rd_en) begin
            if (is_reg(addr, `ADCC_OFF_MUX)) begin
                s_nxt.rdata = s_r.mux;
            end else if (is_reg(addr, `ADCC_OFF_CSRA)) begin
                s_nxt.rdata = {s_r.en, s_r.state == ADCC_CONV, s_r.ate,
                               s_r.flag, s_r.ie, s_r.ps};
            end else if (is_reg(addr, `ADCC_OFF_CTRLB)) begin
                s_nxt.rdata = {5'h00, s_r.trig_sel};
            end else if (is_reg(addr, `ADCC_OFF_AMISC)) begin
                s_nxt.rdata = {5'h00, s_r.ext_ref, 2'h0};
            end else if (is_reg(addr, `ADCC_OFF_RES_LO)) begin
                s_nxt.rdata = link.low_byte;
            end else if (is_reg(addr, `ADCC_OFF_RES_HI)) begin
                s_nxt.rdata = link.high_byte;
            end
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            s_r <= '0;
            s_r.state <= ADCC_IDLE;
            s_r.mux <= `ADCC_MUX_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rdata = s_r.rdata;
    assign converter_power = s_r.en;
    assign conv_active = s_r.state == ADCC_CONV;
    assign ref_source = s_r.ref_out;
    assign input_kind = s_r.kind;
    assign se_channel = s_r.se;
    assign diff_pair = s_r.pair;
    assign gain_20x = s_r.g20;
    assign irq_request = s_r.irq;

endmodule : adcc_top

// ===== adcc_consts.svh
// Offsets, field positions, reset values and timing counts of the converter.
`ifndef ADCC_CONSTS_SVH
`define ADCC_CONSTS_SVH

// ------------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------------
`define ADCC_OFF_MUX 3'h0
`define ADCC_OFF_CSRA 3'h1
`define ADCC_OFF_CTRLB 3'h2
`define ADCC_OFF_AMISC 3'h3
`define ADCC_OFF_RES_LO 3'h4
`define ADCC_OFF_RES_HI 3'h5

// ------------------------------------------------------------------
// Field positions
// ------------------------------------------------------------------
`define ADCC_MUX_REF_HI 7
`define ADCC_MUX_REF_LO 6
`define ADCC_MUX_LADJ 5
`define ADCC_CSRA_EN 7
`define ADCC_CSRA_START 6
`define ADCC_CSRA_ATE 5
`define ADCC_CSRA_FLAG 4
`define ADCC_CSRA_IE 3
`define ADCC_AMISC_EXTREF 2

// ------------------------------------------------------------------
// Reset values and timing counts
// ------------------------------------------------------------------
`define ADCC_MUX_RST 8'h00
`define ADCC_CSRA_RST 8'h00
`define ADCC_CONV_NORMAL 5'h0D
`define ADCC_CONV_LONG 5'h19

`endif

// ===== adcc_pkg.sv
// Types shared by the converter control modules.
package adcc_pkg;

    typedef enum logic [1:0] {
        ADCC_IDLE = 2'b01,
        ADCC_CONV = 2'b10
    } adcc_state_e;

    typedef enum logic [1:0] {
        ADCC_REF_AVCC = 2'h0,
        ADCC_REF_EXT = 2'h1,
        ADCC_REF_1V1 = 2'h2,
        ADCC_REF_2V56 = 2'h3
    } adcc_ref_e;

    typedef enum logic [2:0] {
        ADCC_IN_EXT = 3'h0,
        ADCC_IN_TEMP = 3'h1,
        ADCC_IN_BANDGAP = 3'h2,
        ADCC_IN_VCC4 = 3'h3,
        ADCC_IN_GND = 3'h4,
        ADCC_IN_RSVD = 3'h5,
        ADCC_IN_DIFF = 3'h6
    } adcc_input_e;

    typedef struct packed {
        adcc_state_e state;
        logic [7:0] mux;
        logic en;
        logic ate;
        logic flag;
        logic ie;
        logic [2:0] ps;
        logic [2:0] trig_sel;
        logic ext_ref;
        logic long_next;
        logic long_cur;
        logic [4:0] cnt;
        adcc_ref_e ref_out;
        adcc_input_e kind;
        logic [3:0] se;
        logic [2:0] pair;
        logic g20;
        logic trig_prev;
        logic [7:0] rdata;
        logic irq;
    } adcc_top_s;

    typedef struct packed {
        logic [6:0] cnt;
    } adcc_presc_s;

    typedef struct packed {
        logic [9:0] res;
        logic locked;
    } adcc_res_s;

endpackage : adcc_pkg

// ===== adcc_if.sv
// Signals between the control core, the prescaler and the result holder.
`timescale 1ns/1ns
interface adcc_if;
    logic enable;
    logic restart;
    logic [2:0] div_sel;
    logic tick;
    logic load;
    logic [9:0] data;
    logic left_adjust;
    logic rd_low;
    logic rd_high;
    logic [7:0] low_byte;
    logic [7:0] high_byte;

    modport ctrl (output enable, restart, div_sel, load, data, left_adjust,
                  rd_low, rd_high, input tick, low_byte, high_byte);
    modport presc (input enable, restart, div_sel, output tick);
    modport result (input load, data, left_adjust, rd_low, rd_high,
                    output low_byte, high_byte);
endinterface : adcc_if

// ===== adcc_prescaler.sv
// Converter clock prescaler producing one tick per converter clock.
`timescale 1ns/1ns
module adcc_prescaler import adcc_pkg::*; (
    input wire logic mclk,
    input wire logic rst,
    adcc_if.presc bus
);
    adcc_presc_s s_r;
    adcc_presc_s s_nxt;
    logic [6:0] last;

    function automatic logic [6:0] div_last(input logic [2:0] sel);
        logic [7:0] div;
        div = (sel == 3'h0) ? 8'h02 : (8'h01 << sel);
        return 7'(div - 8'h01);
    endfunction : div_last

    assign last = div_last(bus.div_sel);
    assign bus.tick = bus.enable && (s_r.cnt == last);

    always_comb begin
        s_nxt = s_r;
        if (!bus.enable || bus.restart || s_r.cnt == last) begin
            s_nxt.cnt = 7'h00;
        end else begin
            s_nxt.cnt = s_r.cnt + 7'h01;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule : adcc_prescaler

// ===== adcc_result.sv
// Result holder with byte alignment and low-then-high read locking.
`timescale 1ns/1ns
module adcc_result import adcc_pkg::*; (
    input wire logic mclk,
    input wire logic rst,
    adcc_if.result bus
);
    adcc_res_s s_r;
    adcc_res_s s_nxt;

    // Alignment is applied on the read path so a change shows at once.
    assign bus.low_byte = bus.left_adjust ? {s_r.res[1:0], 6'h00}
                                          : s_r.res[7:0];
    assign bus.high_byte = bus.left_adjust ? s_r.res[9:2]
                                           : {6'h00, s_r.res[9:8]};

    always_comb begin
        s_nxt = s_r;
        if (bus.load && !s_r.locked) begin
            s_nxt.res = bus.data;
        end
        if (bus.rd_low) begin
            s_nxt.locked = 1'b1;
        end else if (bus.rd_high) begin
            s_nxt.locked = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule : adcc_result

// ===== adcc_top_monitor.sv
// Port checker for the converter control top.
`timescale 1ns/1ns
module adcc_top_monitor (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic [7:0] rdata,
    input wire logic global_irq_enable,
    input wire logic irq_vector_ack,
    input wire logic converter_power,
    input wire logic conv_active,
    input wire logic [1:0] ref_source,
    input wire logic [2:0] input_kind,
    input wire logic [3:0] se_channel,
    input wire logic [2:0] diff_pair,
    input wire logic gain_20x,
    input wire logic irq_request
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    a_reset_clear: assert property ($fell(rst) |-> rdata == 8'h00
        && !converter_power && !conv_active && !irq_request)
        else $error("outputs not clear after reset");
    a_off_idle: assert property (!converter_power |-> !conv_active)
        else $error("conversion while powered off");
    a_abort_now: assert property (wr_en && addr == 3'h1 && !wdata[7]
        |=> !conv_active && !converter_power) else $error("no abort");
    a_start_go: assert property (wr_en && addr == 3'h1
        && wdata[7:6] == 2'h3 && !conv_active |=> conv_active)
        else $error("start write ignored");
    a_busy_min: assert property ($rose(conv_active)
        |-> conv_active[*8]) else $error("conversion too short");
    a_sel_stable: assert property (conv_active && $past(conv_active)
        |-> $stable({ref_source, input_kind, se_channel}))
        else $error("selection moved during conversion");
    a_se_code: assert property (input_kind inside {[3'h1:3'h5]}
        |-> se_channel == input_kind + 4'hA) else $error("bad input kind");
    a_diff_code: assert property (input_kind == 3'h6
        |-> se_channel == {diff_pair, gain_20x}) else $error("bad pair");
    a_irq_gate: assert property (irq_request
        |-> $past(global_irq_enable)) else $error("irq without global");
    a_vec_clear: assert property (irq_vector_ack && !conv_active
        |=> !irq_request) else $error("vector did not clear");
    c_done: cover property ($fell(conv_active));
    c_irq: cover property ($rose(irq_request));
    c_diff: cover property (input_kind == 3'h6);
endmodule : adcc_top_monitor

bind adcc_top adcc_top_monitor mon (.mclk, .rst, .addr, .wdata, .wr_en,
    .rdata, .global_irq_enable, .irq_vector_ack, .converter_power,
    .conv_active, .ref_source, .input_kind, .se_channel, .diff_pair,
    .gain_20x, .irq_request);

// ===== adcc_core_model.sv
// Behavioural converter core giving a new result for each conversion.
`timescale 1ns/1ns
module adcc_core_model (
    input wire logic mclk,
    input wire logic conv_active,
    output logic [9:0] core_result
);
    logic [9:0] res_r = 10'h2C6;
    logic prev_r = 1'b0;
    // Outside a conversion the value is inverted so a stale sample shows.
    assign core_result = conv_active ? res_r : ~res_r;
    always @(posedge mclk) begin
        prev_r <= conv_active;
        if (conv_active && !prev_r) begin
            res_r <= res_r + 10'h13B;
        end
    end
endmodule : adcc_core_model

// ===== adcc_top_tb_top.sv
// Self-checking bench for the converter control top.
`timescale 1ns/1ns
module adcc_top_tb_top;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic gie = 1'b0;
    logic ack = 1'b0;
    logic [7:0] trig = 8'h00;
    logic [9:0] core_result, r;
    logic [7:0] rdata, d;
    logic converter_power, conv_active, gain_20x, irq_request;
    logic [1:0] ref_source;
    logic [2:0] input_kind, diff_pair, ek;
    logic [3:0] se_channel;
    int n_errors = 0;
    int checked = 0;
    int cyc = 0;
    int n;
    adcc_top dut (.mclk, .rst, .addr, .wdata, .wr_en, .rd_en, .rdata,
        .global_irq_enable(gie), .irq_vector_ack(ack),
        .trigger_flags(trig), .core_result, .converter_power, .conv_active,
        .ref_source, .input_kind, .se_channel, .diff_pair, .gain_20x,
        .irq_request);
    adcc_core_model pm (.mclk, .conv_active, .core_result);
    initial begin
        forever #5 mclk = ~mclk;
    end
    // A hang counts as a mismatch and goes to the closing report.
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            stop_test();
        end
    end
    task automatic chk(input logic [9:0] s, input logic [9:0] e);
        checked++;
        if (s !== e) begin
            n_errors++;
            $display("mismatch at %0t seen %h exp %h", $time, s, e);
        end
    endtask : chk
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge mclk);
        addr <= a;
        wdata <= v;
        wr_en <= 1'b1;
        @(posedge mclk);
        wr_en <= 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] a);
        @(posedge mclk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge mclk);
        rd_en <= 1'b0;
        #1 d = rdata;
    endtask : rd
    task automatic fin(input int e);
        do begin
            @(posedge mclk);
            #1 n++;
        end while (conv_active === 1'b1 && n < 9000);
        chk(10'(n < 9000), 10'h001);
        if (e > 0) begin
            chk(10'(n >= e - 2 && n <= e + e / 8), 10'h001);
        end
    endtask : fin
    task automatic go(input logic [7:0] c, input int e);
        wr(3'h1, c);
        n = 1;
        fin(e);
    endtask : go
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : stop_test
    initial begin
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        rd(3'h0); chk(d, 8'h00);
        rd(3'h1); chk(d, 8'h00);
        $display("test reset done");
        wr(3'h0, 8'h4B);
        go(8'hC0, 50);
        chk({ref_source, input_kind}, {2'h2, 3'h1});
        rd(3'h1); chk(d, 8'h90);
        go(8'hC0, 26);
        wr(3'h0, 8'hCB);
        go(8'hC3, 200);
        chk(ref_source, 2'h3);
        $display("test timing done");
        r = pm.res_r;
        rd(3'h4); chk(d, r[7:0]);
        go(8'hC0, 26);
        wr(3'h0, 8'hEB);
        rd(3'h5); chk(d, r[9:2]);
        wr(3'h1, 8'hC0);
        rd(3'h1); chk(d[6], 1'b1);
        wr(3'h0, 8'hCB);
        rd(3'h5); chk(d, r[9:8]);
        fin(0);
        r = pm.res_r;
        wr(3'h1, 8'h80);
        rd(3'h1); chk(d, 8'h90);
        rd(3'h4); chk(d, r[7:0]);
        rd(3'h5); chk(d, r[9:8]);
        $display("test result done");
        gie <= 1'b1;
        wr(3'h1, 8'h98);
        rd(3'h1); chk(d, 8'h88);
        go(8'hC8, 26); chk(irq_request, 1'b1);
        @(posedge mclk);
        ack <= 1'b1;
        @(posedge mclk);
        ack <= 1'b0;
        rd(3'h1); chk({d, irq_request}, {8'h88, 1'b0});
        gie <= 1'b0;
        go(8'hC8, 26); chk(irq_request, 1'b0);
        $display("test interrupt done");
        wr(3'h2, 8'h02);
        wr(3'h1, 8'hB0);
        trig <= 8'h04;
        n = 0;
        while (conv_active !== 1'b1 && n < 8) begin
            @(posedge mclk);
            #1 n++;
        end
        chk(conv_active, 1'b1);
        fin(0);
        trig <= 8'h00;
        wr(3'h2, 8'h00);
        rd(3'h1); chk(d, 8'hB0);
        wr(3'h1, 8'hC0);
        wr(3'h1, 8'h00);
        rd(3'h1); chk(d, 8'h10);
        chk({converter_power, conv_active}, 2'h0);
        $display("test trigger done");
        wr(3'h1, 8'h90);
        for (int i = 0; i < 32; i++) begin
            wr(3'h0, {i[1:0], 1'b0, i[4:0]});
            go(8'hC0, 50);
            ek = i[4] ? 3'h6 : (i > 10) ? 3'(i - 10) : 3'h0;
            chk({ref_source, input_kind}, {i[0], i[1] & i[0], ek});
            chk(se_channel, i[3:0]);
            if (i[4]) begin
                chk({diff_pair, gain_20x}, i[3:0]);
            end
        end
        wr(3'h3, 8'h04);
        wr(3'h0, 8'h00);
        go(8'hC0, 50);
        chk(ref_source, 2'h1);
        $display("test codes done");
        stop_test();
    end
endmodule : adcc_top_tb_top
